// ### logic/sac_actuator.sv
// general control of one shutter / venetian blind motor channel
// assumes word-only ahb-lite access, one slave on the bus, synchronous inputs
`default_nettype none

module sac_actuator (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic [31:0] hrdata_o,
  output logic hresp_o,
  output logic motor_up_o,
  output logic motor_down_o,
  output logic pos_send_o,
  output logic [6:0] pos_val_o,
  output logic mov_send_o,
  output logic mov_val_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_CALIB} sac_state_e;

  typedef struct packed {
    sac_state_e state;
    logic dn;
    logic utgt;
    logic [6:0] tgt;
    logic one;
    logic lim_mv;
    logic [6:0] pos;
    logic [15:0] sub;
    logic [6:0] steps;
    logic pend_vld;
    logic [6:0] pend_tgt;
    logic [13:0] cfg;
    logic lim_en;
    logic [6:0] upper;
    logic [6:0] lower;
    logic [6:0] rec_pos;
    logic [6:0] rec_lou;
    logic [15:0] travel;
    logic aph;
    logic awr;
    logic [7:0] aadr;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic mot_up;
    logic mot_dn;
    logic pos_send;
    logic mov_send;
    logic mov_val;
  } sac_st_s;

  sac_st_s st_ff;
  sac_st_s nxt_st;
  logic tick;
  logic wr_hit;
  logic wr_move;
  logic wr_stop;
  logic wr_pos;
  logic wr_evt;
  logic lim_act;
  logic louvre_mode;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // limit and recovery percent values are kept on the five percent grid
  function automatic logic [6:0] snap5(input logic [6:0] v);
    logic [6:0] c;
    c = (v > sac_pkg::PCT_FULL) ? sac_pkg::PCT_FULL : v;
    return c - (c % sac_pkg::PCT_STEP);
  endfunction : snap5

  function automatic logic [6:0] clamp(input logic [6:0] v, input logic [6:0] lo,
                                       input logic [6:0] hi);
    logic [6:0] c;
    c = (v > sac_pkg::PCT_FULL) ? sac_pkg::PCT_FULL : v;
    if (c < lo) c = lo;
    if (c > hi) c = hi;
    return c;
  endfunction : clamp

  // start a run; a targeted run already at its target does not move
  function automatic sac_st_s start_run(input sac_st_s c, input logic dn,
                                        input logic utgt, input logic [6:0] tgt,
                                        input logic one, input logic lim);
    sac_st_s r;
    r = c;
    r.steps = 7'h00;
    r.sub = 16'h0000;
    r.utgt = utgt;
    r.tgt = tgt;
    r.one = one;
    r.lim_mv = lim;
    r.dn = utgt ? (tgt > c.pos) : dn;
    r.state = (utgt && tgt == c.pos) ? ST_IDLE : ST_RUN;
    return r;
  endfunction : start_run

  function automatic sac_st_s start_cal(input sac_st_s c);
    sac_st_s r;
    r = c;
    r.state = ST_CALIB;
    r.dn = 1'b0;
    r.steps = 7'h00;
    r.sub = 16'h0000;
    r.one = 1'b0;
    r.utgt = 1'b0;
    r.lim_mv = 1'b0;
    return r;
  endfunction : start_cal

  sac_tick u_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // bus write decode, taken in the data phase
  // ----------------------------------------------------------------
  assign wr_hit = st_ff.aph && st_ff.awr;
  assign wr_move = wr_hit && st_ff.aadr == sac_pkg::OFS_MOVE;
  assign wr_stop = wr_hit && st_ff.aadr == sac_pkg::OFS_STOP;
  assign wr_pos = wr_hit && st_ff.aadr == sac_pkg::OFS_POS &&
                  st_ff.cfg[sac_pkg::CFG_POSCMD_BIT];
  assign wr_evt = wr_hit && st_ff.aadr == sac_pkg::OFS_EVENT;
  assign louvre_mode = st_ff.cfg[sac_pkg::CFG_MODE_BIT];
  assign lim_act = st_ff.cfg[sac_pkg::CFG_LIMCFG_BIT] && st_ff.lim_en;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // order: bus pipeline, motion step, commands, system events, reports
  always_comb begin
    logic [6:0] t;
    logic dn_cmd;
    t = 7'h00;
    dn_cmd = hwdata_i[sac_pkg::MOVE_DIR_BIT];
    nxt_st = st_ff;
    nxt_st.pos_send = 1'b0;
    nxt_st.mov_send = 1'b0;
    nxt_st.hresp = 1'b0;
    // one wait state per transfer so read data leaves a flip-flop
    if (st_ff.aph) begin
      nxt_st.aph = 1'b0;
      nxt_st.hready = 1'b1;
      if (!st_ff.awr) begin
        case (st_ff.aadr)
          sac_pkg::OFS_CFG: nxt_st.hrdata = {18'h0_0000, st_ff.cfg};
          sac_pkg::OFS_LIMEN: nxt_st.hrdata = {31'h0000_0000, st_ff.lim_en};
          sac_pkg::OFS_UPPER: nxt_st.hrdata = {25'h000_0000, st_ff.upper};
          sac_pkg::OFS_LOWER: nxt_st.hrdata = {25'h000_0000, st_ff.lower};
          sac_pkg::OFS_RECPOS: nxt_st.hrdata = {17'h0_0000, st_ff.rec_lou, 1'b0,
                                                st_ff.rec_pos};
          sac_pkg::OFS_STATUS: nxt_st.hrdata = {21'h00_0000,
                                                st_ff.state == ST_CALIB, st_ff.dn,
                                                st_ff.state != ST_IDLE, 1'b0, st_ff.pos};
          sac_pkg::OFS_TRAVEL: nxt_st.hrdata = {16'h0000, st_ff.travel};
          default: nxt_st.hrdata = 32'h0000_0000; // unmapped and write-only read zero
        endcase
      end
    end else if (hsel_i && hready_i && htrans_i[1]) begin
      nxt_st.aph = 1'b1;
      nxt_st.awr = hwrite_i;
      nxt_st.aadr = haddr_i[7:0];
      nxt_st.hready = 1'b0;
    end
    // plain storing writes
    if (wr_hit) begin
      case (st_ff.aadr)
        sac_pkg::OFS_CFG: nxt_st.cfg = hwdata_i[13:0];
        sac_pkg::OFS_LIMEN: nxt_st.lim_en = hwdata_i[0];
        sac_pkg::OFS_UPPER: nxt_st.upper = snap5(hwdata_i[6:0]);
        sac_pkg::OFS_LOWER: nxt_st.lower = snap5(hwdata_i[6:0]);
        sac_pkg::OFS_RECPOS: begin
          nxt_st.rec_pos = snap5(hwdata_i[6:0]);
          nxt_st.rec_lou = snap5(hwdata_i[sac_pkg::RECPOS_LOU_LSB +: 7]);
        end
        sac_pkg::OFS_TRAVEL: nxt_st.travel = hwdata_i[15:0];
        default: nxt_st.cfg = st_ff.cfg;
      endcase
    end
    // run time per percent is travel ticks
    if (st_ff.state != ST_IDLE && tick) begin
      if (st_ff.sub + 16'h0001 >= st_ff.travel) begin
        nxt_st.sub = 16'h0000;
        nxt_st.steps = st_ff.steps + 7'h01;
        if (st_ff.dn && st_ff.pos < sac_pkg::PCT_FULL) begin
          nxt_st.pos = st_ff.pos + 7'h01;
        end else if (!st_ff.dn && st_ff.pos != 7'h00) begin
          nxt_st.pos = st_ff.pos - 7'h01;
        end
        // end on target, single step or timeout
        if (st_ff.state == ST_RUN) begin
          if (st_ff.one || (st_ff.utgt && nxt_st.pos == st_ff.tgt) ||
              nxt_st.steps >= sac_pkg::MOVE_STEPS) begin
            nxt_st.state = ST_IDLE;
          end
        end else if (nxt_st.steps >= sac_pkg::MOVE_STEPS) begin
          // calibration done: top end reached, position is exact again
          nxt_st.pos = 7'h00;
          nxt_st.state = ST_IDLE;
          if (st_ff.pend_vld) begin
            nxt_st.pend_vld = 1'b0;
            nxt_st = start_run(nxt_st, 1'b0, 1'b1, st_ff.pend_tgt, 1'b0, 1'b0);
          end
        end
      end else begin
        nxt_st.sub = st_ff.sub + 16'h0001;
      end
    end
    // all commands, high priority moves included, are ignored while calibrating
    if (st_ff.state != ST_CALIB) begin
      if (wr_move) begin
        if (lim_act && !hwdata_i[sac_pkg::MOVE_HI_BIT]) begin
          // stop at the limit, never start beyond it
          t = dn_cmd ? st_ff.lower : st_ff.upper;
          if (dn_cmd ? (st_ff.pos >= t) : (st_ff.pos <= t)) begin
            nxt_st.state = ST_IDLE;
          end else begin
            nxt_st = start_run(nxt_st, dn_cmd, 1'b1, t, 1'b0, 1'b1);
          end
        end else begin
          nxt_st = start_run(nxt_st, dn_cmd, 1'b0, 7'h00, 1'b0, 1'b0);
        end
      end else if (wr_pos) begin
        t = lim_act ? clamp(hwdata_i[6:0], st_ff.upper, st_ff.lower)
                    : clamp(hwdata_i[6:0], 7'h00, sac_pkg::PCT_FULL);
        nxt_st = start_run(nxt_st, 1'b0, 1'b1, t, 1'b0, lim_act);
      end else if (wr_stop) begin
        if (st_ff.state == ST_RUN) begin
          // any value halts a running motor
          nxt_st.state = ST_IDLE;
        end else if (louvre_mode) begin
          nxt_st = start_run(nxt_st, hwdata_i[0], 1'b0, 7'h00, 1'b1, 1'b0);
        end
      end
    end
    // system events outrank every command
    if (wr_evt && hwdata_i[sac_pkg::EV_DL_BIT]) begin
      // limits enable takes its download value
      nxt_st.lim_en = st_ff.cfg[sac_pkg::CFG_LIMDL_BIT];
      if (st_ff.cfg[sac_pkg::CFG_DLCAL_BIT]) begin
        nxt_st = start_cal(nxt_st);
      end
    end
    if (wr_evt && hwdata_i[sac_pkg::EV_RECOV_BIT]) begin
      // off, on or keep the held value
      case (st_ff.cfg[sac_pkg::CFG_LIMRC_LSB +: 2])
        sac_pkg::LIMRC_OFF: nxt_st.lim_en = 1'b0;
        sac_pkg::LIMRC_ON: nxt_st.lim_en = 1'b1;
        default: nxt_st.lim_en = nxt_st.lim_en;
      endcase
      case (st_ff.cfg[sac_pkg::CFG_RECOV_LSB +: 3])
        sac_pkg::REC_UP: nxt_st = start_run(nxt_st, 1'b0, 1'b0, 7'h00, 1'b0, 1'b0);
        sac_pkg::REC_DOWN: nxt_st = start_run(nxt_st, 1'b1, 1'b0, 7'h00, 1'b0, 1'b0);
        sac_pkg::REC_CAL: nxt_st = start_cal(nxt_st);
        sac_pkg::REC_POS: begin
          nxt_st = start_cal(nxt_st);
          nxt_st.pend_vld = 1'b1;
          nxt_st.pend_tgt = st_ff.rec_pos;
        end
        default: nxt_st.pend_vld = nxt_st.pend_vld; // keep what the motion step left
      endcase
      if (st_ff.cfg[sac_pkg::CFG_POSRPT_LSB +: 2] == sac_pkg::RPT_CHG) begin
        nxt_st.pos_send = 1'b1;
      end
    end
    if ((nxt_st.pos != st_ff.pos &&
         st_ff.cfg[sac_pkg::CFG_POSRPT_LSB +: 2] == sac_pkg::RPT_CHG) ||
        (wr_evt && hwdata_i[sac_pkg::EV_POSREQ_BIT] &&
         st_ff.cfg[sac_pkg::CFG_POSRPT_LSB +: 2] != sac_pkg::RPT_OFF)) begin
      nxt_st.pos_send = 1'b1;
    end
    // direction value latched at each start
    if (nxt_st.state != ST_IDLE && (st_ff.state == ST_IDLE || nxt_st.dn != st_ff.dn)) begin
      nxt_st.mov_val = nxt_st.dn;
      if (st_ff.cfg[sac_pkg::CFG_MOVRPT_LSB +: 2] == sac_pkg::RPT_CHG) begin
        nxt_st.mov_send = 1'b1;
      end
    end
    if (wr_evt && hwdata_i[sac_pkg::EV_MOVREQ_BIT] &&
        st_ff.cfg[sac_pkg::CFG_MOVRPT_LSB +: 2] != sac_pkg::RPT_OFF) begin
      nxt_st.mov_send = 1'b1;
    end
    // motor relays follow run state, never both
    nxt_st.mot_up = nxt_st.state != ST_IDLE && !nxt_st.dn;
    nxt_st.mot_dn = nxt_st.state != ST_IDLE && nxt_st.dn;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.cfg <= sac_pkg::CFG_RST;
      st_ff.upper <= sac_pkg::UPPER_RST;
      st_ff.lower <= sac_pkg::LOWER_RST;
      st_ff.travel <= sac_pkg::TRAVEL_RST;
      st_ff.hready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hreadyout_o = st_ff.hready;
  assign hrdata_o = st_ff.hrdata;
  assign hresp_o = st_ff.hresp;
  assign motor_up_o = st_ff.mot_up;
  assign motor_down_o = st_ff.mot_dn;
  assign pos_send_o = st_ff.pos_send;
  assign pos_val_o = st_ff.pos;
  assign mov_send_o = st_ff.mov_send;
  assign mov_val_o = st_ff.mov_val;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  chk_motor_excl: assert property (!(motor_up_o && motor_down_o))
    else $error("both motor relays on");
  chk_stop_halts: assert property (wr_stop && st_ff.state == ST_RUN && !wr_evt
                                   |=> !motor_up_o && !motor_down_o)
    else $error("stop did not halt running motor");
  chk_stop_rest: assert property (wr_stop && !louvre_mode && st_ff.state == ST_IDLE &&
                                  !wr_evt |=> st_ff.state == ST_IDLE)
    else $error("stop at rest moved the shutter");
  chk_louvre_step: assert property (wr_stop && louvre_mode && st_ff.state == ST_IDLE &&
                                    !wr_evt |=> motor_down_o == $past(hwdata_i[0]) &&
                                    motor_up_o == !$past(hwdata_i[0]))
    else $error("louvre step direction wrong");
  chk_dir_value: assert property (motor_down_o |-> mov_val_o)
    else $error("direction report not down");
  chk_pos_range: assert property (st_ff.pos <= sac_pkg::PCT_FULL)
    else $error("position beyond full travel");
  chk_limit_hold: assert property (st_ff.lim_mv && motor_up_o
                                   |-> st_ff.pos >= st_ff.upper)
    else $error("limited move passed upper limit");
  chk_pos_report: assert property ($changed(st_ff.pos) &&
                                   $past(st_ff.cfg[3:2]) == sac_pkg::RPT_CHG
                                   |-> pos_send_o)
    else $error("position change not reported");
  chk_mov_report: assert property ($rose(motor_up_o || motor_down_o) &&
                                   $past(st_ff.cfg[5:4]) == sac_pkg::RPT_CHG
                                   |-> mov_send_o)
    else $error("movement start not reported");
  chk_recov_calib: assert property (wr_evt && hwdata_i[sac_pkg::EV_RECOV_BIT] &&
                                    st_ff.cfg[9:7] == sac_pkg::REC_POS
                                    |=> st_ff.state == ST_CALIB ##0 st_ff.pend_vld)
    else $error("recovery preset skipped calibration");
  chk_bus_wait: assert property (st_ff.aph |=> hreadyout_o ##1 1'b1)
    else $error("bus wait state longer than one");

  cov_louvre_step: cover property (wr_stop && louvre_mode && st_ff.state == ST_IDLE);
  cov_calib_done: cover property (st_ff.state == ST_CALIB ##1 st_ff.state == ST_RUN);
  cov_limited_stop: cover property (st_ff.lim_mv && st_ff.state == ST_RUN
                                    ##1 st_ff.state == ST_IDLE);
  cov_pos_report: cover property (pos_send_o);
endmodule : sac_actuator

`default_nettype wire

// ### logic/sac_pkg.sv
// shared constants of the shutter actuator general control block
// assumes a single 20 MHz clock and word-only ahb-lite register access
`default_nettype none

package sac_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_NS = 100000; // base tick of the position estimator, 0.1 ms
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] MOVE_STEPS = 7'd110; // travel range plus ten percent
  localparam logic [6:0] PCT_FULL = 7'd100;
  localparam logic [6:0] PCT_STEP = 7'd5;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MOVE = 8'h04;
  localparam logic [7:0] OFS_STOP = 8'h08;
  localparam logic [7:0] OFS_POS = 8'h0C;
  localparam logic [7:0] OFS_LIMEN = 8'h10;
  localparam logic [7:0] OFS_UPPER = 8'h14;
  localparam logic [7:0] OFS_LOWER = 8'h18;
  localparam logic [7:0] OFS_RECPOS = 8'h1C;
  localparam logic [7:0] OFS_EVENT = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_TRAVEL = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_MODE_BIT = 0;   // 0 shutter, 1 venetian blind
  localparam int CFG_POSCMD_BIT = 1;
  localparam int CFG_POSRPT_LSB = 2; // 2 bits
  localparam int CFG_MOVRPT_LSB = 4; // 2 bits
  localparam int CFG_DLCAL_BIT = 6;
  localparam int CFG_RECOV_LSB = 7;  // 3 bits
  localparam int CFG_LIMCFG_BIT = 10;
  localparam int CFG_LIMDL_BIT = 11;
  localparam int CFG_LIMRC_LSB = 12; // 2 bits
  localparam int MOVE_DIR_BIT = 0;   // 1 down
  localparam int MOVE_HI_BIT = 1;    // priority above the limits
  localparam int RECPOS_LOU_LSB = 8;
  localparam int EV_DL_BIT = 0;
  localparam int EV_RECOV_BIT = 1;
  localparam int EV_POSREQ_BIT = 2;
  localparam int EV_MOVREQ_BIT = 3;
  localparam int ST_RUN_BIT = 8;
  localparam int ST_DIR_BIT = 9;
  localparam int ST_CAL_BIT = 10;

  // ----------------------------------------------------------------
  // encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RPT_OFF = 2'h0;
  localparam logic [1:0] RPT_REQ = 2'h1;
  localparam logic [1:0] RPT_CHG = 2'h2;
  localparam logic [2:0] REC_NONE = 3'h0;
  localparam logic [2:0] REC_UP = 3'h1;
  localparam logic [2:0] REC_DOWN = 3'h2;
  localparam logic [2:0] REC_CAL = 3'h3;
  localparam logic [2:0] REC_POS = 3'h4;
  localparam logic [1:0] LIMRC_OFF = 2'h0;
  localparam logic [1:0] LIMRC_ON = 2'h1;
  localparam logic [1:0] LIMRC_KEEP = 2'h2;
  localparam logic [13:0] CFG_RST = 14'h0000;
  localparam logic [6:0] UPPER_RST = 7'h00;
  localparam logic [6:0] LOWER_RST = 7'h64;
  localparam logic [15:0] TRAVEL_RST = 16'h0064; // run time per percent step in ticks
endpackage : sac_pkg

`default_nettype wire

// ### logic/sac_tick.sv
// base tick divider for the shutter actuator
// assumes the 20 MHz system clock; emits one-cycle enable pulses
`default_nettype none

module sac_tick (
  input wire logic clk_i,
  input wire logic nrst_i,
  output logic tick_o
);
  typedef struct packed {
    logic [11:0] cnt;
    logic tick;
  } sac_tick_s;

  sac_tick_s tick_ff;
  sac_tick_s nxt_tick;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // free-running count, one pulse per wrap
  always_comb begin
    nxt_tick = tick_ff;
    nxt_tick.tick = 1'b0;
    if (tick_ff.cnt == 12'(sac_pkg::TICK_CYC - 1)) begin
      nxt_tick.cnt = 12'h000;
      nxt_tick.tick = 1'b1;
    end else begin
      nxt_tick.cnt = tick_ff.cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      tick_ff <= '0;
    end else begin
      tick_ff <= nxt_tick;
    end
  end

  assign tick_o = tick_ff.tick;
endmodule : sac_tick

`default_nettype wire

// ### verif/sac_far_model.sv
// far-side model: bus listener for the actuator telegrams and its motor
// assumes send pulses last one clock; counts a relay clash if both close
`default_nettype none
module sac_far_model (
  input wire logic clk_i,
  input wire logic up_i,
  input wire logic down_i,
  input wire logic pos_send_i,
  input wire logic [6:0] pos_val_i,
  input wire logic mov_send_i,
  input wire logic mov_val_i,
  output var int npos_o,
  output var int nmov_o,
  output var logic [6:0] lpos_o,
  output var logic ldir_o,
  output var int clash_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // empty mailbox until the first telegram arrives
  initial begin
    npos_o = 0;
    nmov_o = 0;
    clash_o = 0;
    lpos_o = 7'h7F;
    ldir_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (pos_send_i === 1'b1) begin
      npos_o++;
      lpos_o = pos_val_i;
    end
    if (mov_send_i === 1'b1) begin
      nmov_o++;
      ldir_o = mov_val_i;
    end
    // both windings powered would burn the motor
    if (up_i === 1'b1 && down_i === 1'b1) clash_o++;
  end
endmodule : sac_far_model
`default_nettype wire

// ### verif/shutter_actuator_general_control_tb.sv
// self-checking bench for sac_actuator, registers over ahb-lite
// assumes one bus slave; travel set to one tick a step to keep runs short
`default_nettype none
module shutter_actuator_general_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hready, hresp, up, down, psend, msend, mval, ldir;
  logic [6:0] pval, lpos;
  int miscompares = 0, checks_done = 0, cyc = 0, npos, nmov, clash;
  always #25 clk_i = ~clk_i;
  sac_actuator u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp),
    .motor_up_o(up), .motor_down_o(down), .pos_send_o(psend), .pos_val_o(pval),
    .mov_send_o(msend), .mov_val_o(mval));
  sac_far_model u_far (.clk_i(clk_i), .up_i(up), .down_i(down), .pos_send_i(psend),
    .pos_val_i(pval), .mov_send_i(msend), .mov_val_i(mval), .npos_o(npos),
    .nmov_o(nmov), .lpos_o(lpos), .ldir_o(ldir), .clash_o(clash));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // a hang is cut short here and still reaches the verdict
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [31:0] mot();
    return {30'h0, up, down};
  endfunction : mot
  // one single word transfer; waits on hready, never on a fixed count
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic wait_idle;
    while (up === 1'b1 || down === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
  endtask : wait_idle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rdchk(8'h00, 32'h0, "cfg");
    rdchk(8'h18, 32'h64, "lower");
    rdchk(8'h3C, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    bus(1'b1, 8'h14, 32'h7);
    rdchk(8'h14, 32'h5, "upper");
    bus(1'b1, 8'h28, 32'h1);
    $display("regs done");
  endtask : t_regs
  task automatic t_shut;
    bus(1'b1, 8'h08, 32'h0);
    chk("motor", 32'h0, mot());
    bus(1'b1, 8'h04, 32'h1);
    chk("motor", 32'h1, mot());
    chk("dir", 32'h1, {31'h0, mval});
    bus(1'b1, 8'h08, 32'h0);
    chk("motor", 32'h0, mot());
    $display("shutter done");
  endtask : t_shut
  task automatic t_lou;
    bus(1'b1, 8'h00, 32'h29);
    bus(1'b1, 8'h08, 32'h1);
    chk("motor", 32'h1, mot());
    wait_idle();
    chk("pos", 32'h1, {25'h0, pval});
    chk("dir sent", 32'h1, {31'h0, ldir});
    bus(1'b1, 8'h08, 32'h0);
    chk("motor", 32'h2, mot());
    wait_idle();
    chk("pos msgs", 32'h2, 32'(npos));
    chk("mov msgs", 32'h2, 32'(nmov));
    $display("louvre done");
  endtask : t_lou
  task automatic t_tgt;
    bus(1'b1, 8'h00, 32'h0A);
    bus(1'b1, 8'h0C, 32'h5);
    chk("motor", 32'h1, mot());
    wait_idle();
    // status keeps the last direction (down) after the move has ended
    rdchk(8'h24, 32'h205, "status");
    chk("pos sent", 32'h5, {25'h0, lpos});
    // request-only reporting answers both request bits, one telegram each
    bus(1'b1, 8'h00, 32'h14);
    bus(1'b1, 8'h20, 32'hC);
    rdchk(8'h00, 32'h14, "cfg");
    chk("pos msgs", 32'h8, 32'(npos));
    chk("mov msgs", 32'h3, 32'(nmov));
    $display("target done");
  endtask : t_tgt
  task automatic t_lim;
    bus(1'b1, 8'h00, 32'h402);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h0C, 32'h0);
    chk("motor", 32'h0, mot());
    bus(1'b1, 8'h04, 32'h0);
    chk("motor", 32'h0, mot());
    bus(1'b1, 8'h04, 32'h2);
    chk("motor", 32'h2, mot());
    bus(1'b1, 8'h08, 32'h0);
    chk("motor", 32'h0, mot());
    // raising the upper limit at run time lets a limited move go up again
    bus(1'b1, 8'h14, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    chk("motor", 32'h2, mot());
    bus(1'b1, 8'h08, 32'h0);
    $display("limits done");
  endtask : t_lim
  task automatic t_recov;
    bus(1'b1, 8'h00, 32'h88);
    bus(1'b1, 8'h20, 32'h2);
    chk("motor", 32'h2, mot());
    bus(1'b1, 8'h00, 32'h108);
    bus(1'b1, 8'h20, 32'h2);
    chk("motor", 32'h1, mot());
    bus(1'b1, 8'h08, 32'h0);
    chk("pos msgs", 32'hA, 32'(npos));
    bus(1'b1, 8'h00, 32'hC40);
    bus(1'b1, 8'h20, 32'h1);
    bus(1'b0, 8'h24, 32'h0);
    chk("calibrating", 32'h1, {31'h0, rd[10]});
    rdchk(8'h10, 32'h1, "limen");
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk("motor", 32'h0, mot());
    rdchk(8'h00, 32'h0, "cfg");
    // preset recovery: limits forced on, calibration runs first
    bus(1'b1, 8'h00, 32'h1200);
    bus(1'b1, 8'h1C, 32'hB07);
    rdchk(8'h1C, 32'hA05, "recpos");
    bus(1'b1, 8'h20, 32'h2);
    rdchk(8'h10, 32'h1, "limen");
    rdchk(8'h24, 32'h500, "status");
    chk("clash", 32'h0, 32'(clash));
    $display("recovery done");
  endtask : t_recov
  initial begin
    repeat (3) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_shut();
    t_lou();
    t_tgt();
    t_lim();
    t_recov();
    finish_test();
  end
endmodule : shutter_actuator_general_control_tb
`default_nettype wire
